/* core/fti_pkg.sv */
// shared constants and types for the fan tach and intrusion monitor
package fti_pkg;

	// ----------------------------------------------------------------
	// clocking and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ    = 200_000_000;
	localparam int unsigned REF_HZ    = 22_500;   // 22.5 kHz reference
	localparam int unsigned PULSE_MS  = 20;       // intrusion reset pulse
	// reference period rounds down, pulse length rounds down
	localparam int unsigned REF_DIV   = CLK_HZ / REF_HZ;
	localparam int unsigned PULSE_CYC =
		(CLK_HZ / 1000) * PULSE_MS;

	// ----------------------------------------------------------------
	// bus and data widths
	// ----------------------------------------------------------------
	localparam int unsigned AW   = 8;
	localparam int unsigned DW   = 8;
	localparam int unsigned NFAN = 2;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [AW-1:0] A_CFG    = 8'h00;
	localparam logic [AW-1:0] A_CHMODE = 8'h01;
	localparam logic [AW-1:0] A_FANDIV = 8'h02;
	localparam logic [AW-1:0] A_VAL_A  = 8'h03;
	localparam logic [AW-1:0] A_VAL_B  = 8'h04;
	localparam logic [AW-1:0] A_LIM_A  = 8'h05;
	localparam logic [AW-1:0] A_LIM_B  = 8'h06;
	localparam logic [AW-1:0] A_STAT   = 8'h07;
	localparam logic [AW-1:0] A_MASK   = 8'h08;
	localparam logic [AW-1:0] A_CICLR  = 8'h09;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned CFG_START  = 0;
	localparam int unsigned CFG_INTEN  = 1;
	localparam int unsigned CFG_INTCLR = 3;
	localparam int unsigned CI_BIT     = 7;
	localparam int unsigned DIV_LSB    = 4;   // 2 bits per fan from here
	localparam int unsigned VID_W      = 4;
	localparam int unsigned ST_INTR    = 2;   // fans use bits 0 and 1

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [DW-1:0] CFG_RST  = 8'h00;
	localparam logic [DW-1:0] MASK_RST = 8'h00;
	localparam logic [DW-1:0] LIM_RST  = 8'hFF;
	localparam logic [DW-1:0] CNT_FULL = 8'hFF;
	localparam logic [1:0]    DIV_RST  = 2'h1;  // divide by 2
	localparam logic [NFAN-1:0] CHM_RST = 2'h0; // both pins are tach

	// sequencer states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ARM  = 3'b001,
		S_P1   = 3'b010,
		S_P2   = 3'b011,
		S_DONE = 3'b100
	} fti_state_t;

endpackage

/* core/fti_tach_sync.sv */
// tach input synchroniser and rising edge detector
`timescale 1ns/1ps
module fti_tach_sync (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic tach_raw,
	output logic      tach_rise
);

	logic s1_r;
	logic s2_r;
	logic s3_r;

	// ----------------------------------------------------------------
	// two stage sync, then a history flop for the edge
	// ----------------------------------------------------------------
	// s1 feeds only s2; slow tach slopes can sit near threshold
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s1_r      <= 1'b0;
			s2_r      <= 1'b0;
			s3_r      <= 1'b0;
			tach_rise <= 1'b0;
		end else begin
			s1_r      <= tach_raw;
			s2_r      <= s1_r;
			s3_r      <= s2_r;
			tach_rise <= s2_r & ~s3_r;
		end
	end

endmodule

/* core/fti_top.sv */
// fan period measurement, limit status, interrupt and intrusion logic
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module fti_top #(
	parameter int unsigned REF_DIV   = fti_pkg::REF_DIV,
	parameter int unsigned PULSE_CYC = fti_pkg::PULSE_CYC
) (
	input  wire logic                       sys_clk,
	input  wire logic                       sys_rst,
	input  wire logic [fti_pkg::AW-1:0]     reg_addr,
	input  wire logic [fti_pkg::DW-1:0]     reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [fti_pkg::DW-1:0]     reg_rdata,
	input  wire logic                       tach_input_a,
	input  wire logic                       tach_input_b,
	input  wire logic [fti_pkg::VID_W-1:0]  vid_in,
	input  wire logic                       intrusion_pin_i,
	output logic                            intrusion_pin_o,
	output logic                            intrusion_pin_oe,
	output logic                            int_n
);

	localparam int RW = $clog2(REF_DIV);
	localparam int PW = $clog2(PULSE_CYC + 1);
	localparam int DW = fti_pkg::DW;
	localparam int NF = fti_pkg::NFAN;

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic [DW-1:0]          cfg_r;
	logic [NF-1:0]          chmode_r;
	logic [2*NF-1:0]        fandiv_r;
	logic [DW-1:0]          lim_r [NF];
	logic [DW-1:0]          val_r [NF];
	logic [DW-1:0]          mask_r;
	logic [DW-1:0]          stat_r;
	logic [DW-1:0]          stat_nxt;
	logic [DW-1:0]          rdata_nxt;
	logic [RW-1:0]          ref_cnt_r;
	logic [2:0]             pre_cnt_r;
	logic [PW-1:0]          pulse_cnt_r;
	logic                   pulse_oe_r;
	logic [DW-1:0]          cnt_r;
	logic [DW-1:0]          cnt_nxt;
	logic                   fan_sel_r;
	logic                   fan_sel_nxt;
	fti_pkg::fti_state_t    state_r;
	logic [NF-1:0]          tach_raw;
	logic [NF-1:0]          tach_rise;
	logic                   ref_tick;
	logic                   cnt_tick;
	logic                   run;
	logic [NF-1:0]          fan_en;
	logic                   edge_seen;
	logic                   at_full;
	logic                   fan_oor;
	logic                   upd;
	logic                   wr_cfg;
	logic                   wr_ci;
	logic                   rd_stat;
	logic                   int_act;

	// true when the prescaled count should advance this reference tick
	function automatic logic div_hit(input logic [1:0] sel,
		input logic [2:0] pc);
		logic hit;
		hit = 1'b0;
		case (sel)
			2'h0:    hit = 1'b1;
			2'h1:    hit = (pc[0] == 1'b0);
			2'h2:    hit = (pc[1:0] == 2'h0);
			default: hit = (pc == 3'h0);
		endcase
		return hit;
	endfunction

	// ----------------------------------------------------------------
	// tach synchronisers
	// ----------------------------------------------------------------
	assign tach_raw = {tach_input_b, tach_input_a};

	genvar gi;
	generate
		for (gi = 0; gi < NF; gi++) begin : g_sync
			fti_tach_sync u_sync (
				.sys_clk   (sys_clk),
				.sys_rst   (sys_rst),
				.tach_raw  (tach_raw[gi]),
				.tach_rise (tach_rise[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// reference enable and prescaler
	// ----------------------------------------------------------------
	assign ref_tick = (ref_cnt_r == RW'(REF_DIV - 1));

	// one pulse per reference period stands in for the 22.5 kHz clock
	always_ff @(posedge sys_clk) begin
		if (sys_rst || ref_tick) begin
			ref_cnt_r <= '0;
		end else begin
			ref_cnt_r <= ref_cnt_r + RW'(1);
		end
	end

	// free running prescale phase; one phase serves both fans
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pre_cnt_r <= 3'h0;
		end else if (ref_tick) begin
			pre_cnt_r <= pre_cnt_r + 3'h1;
		end
	end

	// counting rate gives count = 1.35e6 / (rpm * divisor)
	assign cnt_tick = ref_tick &
		div_hit(fandiv_r[2*fan_sel_r +: 2], pre_cnt_r);

	// ----------------------------------------------------------------
	// measurement sequencer
	// ----------------------------------------------------------------
	// analog conversion is not tied to this loop beyond the start bit
	assign run = cfg_r[fti_pkg::CFG_START] &
		~cfg_r[fti_pkg::CFG_INTCLR];
	assign fan_en    = ~chmode_r;
	assign edge_seen = tach_rise[fan_sel_r];
	assign at_full   = (cnt_r == fti_pkg::CNT_FULL);
	assign cnt_nxt   = (cnt_tick && !at_full) ?
		cnt_r + DW'(1) : cnt_r;
	assign upd       = (state_r == fti_pkg::S_DONE);
	// a disabled next fan is skipped, so one fan loops on itself
	assign fan_sel_nxt = fan_en[~fan_sel_r] ? ~fan_sel_r : fan_sel_r;

	// walk the fans in turn, two tach periods each
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_r   <= fti_pkg::S_IDLE;
			fan_sel_r <= 1'b0;
			cnt_r     <= '0;
		end else if (!run && state_r != fti_pkg::S_IDLE) begin
			state_r <= fti_pkg::S_IDLE;
		end else begin
			case (state_r)
				fti_pkg::S_IDLE: begin
					if (run && |fan_en) begin
						fan_sel_r <= ~fan_en[0];
						cnt_r     <= '0;
						state_r   <= fti_pkg::S_ARM;
					end
				end
				fti_pkg::S_ARM: begin
					// a stalled fan never edges: time out at full scale
					if (edge_seen) begin
						cnt_r   <= '0;
						state_r <= fti_pkg::S_P1;
					end else begin
						cnt_r <= cnt_nxt;
						if (cnt_nxt == fti_pkg::CNT_FULL) begin
							state_r <= fti_pkg::S_DONE;
						end
					end
				end
				fti_pkg::S_P1: begin
					cnt_r <= cnt_nxt;
					if (cnt_nxt == fti_pkg::CNT_FULL) begin
						state_r <= fti_pkg::S_DONE;
					end else if (edge_seen) begin
						state_r <= fti_pkg::S_P2;
					end
				end
				fti_pkg::S_P2: begin
					cnt_r <= cnt_nxt;
					if (edge_seen || cnt_nxt == fti_pkg::CNT_FULL) begin
						state_r <= fti_pkg::S_DONE;
					end
				end
				fti_pkg::S_DONE: begin
					fan_sel_r <= fan_sel_nxt;
					cnt_r     <= '0;
					// both pins given to the analog side: park until one returns
					if (fan_en == '0) begin
						state_r <= fti_pkg::S_IDLE;
					end else begin
						state_r <= fti_pkg::S_ARM;
					end
				end
				default: begin
					state_r <= fti_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// value store and limit compare
	// ----------------------------------------------------------------
	// larger count means slower fan, so only the low-speed side matters
	assign fan_oor = (cnt_r > lim_r[fan_sel_r]);

	// finished counts land here and stay readable between updates
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			val_r[0] <= '0;
			val_r[1] <= '0;
		end else if (upd) begin
			val_r[fan_sel_r] <= cnt_r;
		end
	end

	// ----------------------------------------------------------------
	// register bus decode
	// ----------------------------------------------------------------
	assign wr_cfg  = reg_wr && (reg_addr == fti_pkg::A_CFG);
	assign wr_ci   = reg_wr && (reg_addr == fti_pkg::A_CICLR) &&
		reg_wdata[fti_pkg::CI_BIT];
	assign rd_stat = reg_rd && (reg_addr == fti_pkg::A_STAT);

	// software writable configuration
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_r    <= fti_pkg::CFG_RST;
			chmode_r <= fti_pkg::CHM_RST;
			fandiv_r <= {fti_pkg::DIV_RST, fti_pkg::DIV_RST};
			lim_r[0] <= fti_pkg::LIM_RST;
			lim_r[1] <= fti_pkg::LIM_RST;
			mask_r   <= fti_pkg::MASK_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				fti_pkg::A_CFG:    cfg_r    <= reg_wdata;
				fti_pkg::A_CHMODE: chmode_r <= reg_wdata[NF-1:0];
				fti_pkg::A_FANDIV: begin
					fandiv_r <= reg_wdata[fti_pkg::DIV_LSB +: 2*NF];
				end
				fti_pkg::A_LIM_A:  lim_r[0] <= reg_wdata;
				fti_pkg::A_LIM_B:  lim_r[1] <= reg_wdata;
				fti_pkg::A_MASK:   mask_r   <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	// read clears first; a same-cycle update or intrusion level wins
	always_comb begin
		stat_nxt = rd_stat ? '0 : stat_r;
		if (upd) begin
			stat_nxt[fan_sel_r] = fan_oor;
		end
		// our own reset pulse holds the pin low, so ignore it then
		if (intrusion_pin_i && !pulse_oe_r) begin
			stat_nxt[fti_pkg::ST_INTR] = 1'b1;
		end
	end

	// status register, untouched by the interrupt clear bit
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stat_r <= '0;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// ----------------------------------------------------------------
	// interrupt output
	// ----------------------------------------------------------------
	assign int_act = |(stat_r & ~mask_r);

	// registered so the pin never glitches during decode
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			int_n <= 1'b1;
		end else begin
			int_n <= ~(int_act & cfg_r[fti_pkg::CFG_INTEN] &
				~cfg_r[fti_pkg::CFG_INTCLR]);
		end
	end

	// ----------------------------------------------------------------
	// intrusion latch reset pulse
	// ----------------------------------------------------------------
	// a rewrite during a pulse restarts the full length
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pulse_cnt_r <= '0;
			pulse_oe_r  <= 1'b0;
		end else if (wr_ci) begin
			pulse_cnt_r <= PW'(PULSE_CYC);
			pulse_oe_r  <= 1'b1;
		end else begin
			if (pulse_cnt_r != '0) begin
				pulse_cnt_r <= pulse_cnt_r - PW'(1);
			end
			pulse_oe_r <= (pulse_cnt_r > PW'(1));
		end
	end

	// open drain: only ever drives low
	assign intrusion_pin_o  = 1'b0;
	assign intrusion_pin_oe = pulse_oe_r;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb begin
		rdata_nxt = '0;
		case (reg_addr)
			fti_pkg::A_CFG:    rdata_nxt = cfg_r;
			fti_pkg::A_CHMODE: rdata_nxt = DW'(chmode_r);
			fti_pkg::A_FANDIV: rdata_nxt = {fandiv_r, vid_in};
			fti_pkg::A_VAL_A:  rdata_nxt = val_r[0];
			fti_pkg::A_VAL_B:  rdata_nxt = val_r[1];
			fti_pkg::A_LIM_A:  rdata_nxt = lim_r[0];
			fti_pkg::A_LIM_B:  rdata_nxt = lim_r[1];
			fti_pkg::A_STAT:   rdata_nxt = stat_r;
			fti_pkg::A_MASK:   rdata_nxt = mask_r;
			fti_pkg::A_CICLR: begin
				rdata_nxt[fti_pkg::CI_BIT] = pulse_oe_r;
			end
			default:           rdata_nxt = '0;
		endcase
	end

	// read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rdata_nxt : '0;
		end
	end

endmodule

/* tb/fti_top_asserts.sv */
// port-level assertions for the fan tach and intrusion monitor
`timescale 1ns/1ps
module fti_top_asserts #(
	parameter int unsigned REF_DIV   = fti_pkg::REF_DIV,
	parameter int unsigned PULSE_CYC = fti_pkg::PULSE_CYC
) (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       tach_input_a,
	input wire logic       tach_input_b,
	input wire logic [3:0] vid_in,
	input wire logic       intrusion_pin_i,
	input wire logic       intrusion_pin_o,
	input wire logic       intrusion_pin_oe,
	input wire logic       int_n
);
	logic [7:0]  cfg_r;
	logic [7:0]  mask_r;
	logic [31:0] cnt_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// settings shadowed from write strobes, needed to predict int_n
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_r  <= 8'h00;
			mask_r <= 8'h00;
		end else if (reg_wr && reg_addr == fti_pkg::A_CFG) begin
			cfg_r <= reg_wdata;
		end else if (reg_wr && reg_addr == fti_pkg::A_MASK) begin
			mask_r <= reg_wdata;
		end
	end
	// cycles since the last pulse request; saturates so it never wraps
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_r <= PULSE_CYC;
		end else if (reg_wr && reg_addr == fti_pkg::A_CICLR
				&& reg_wdata[fti_pkg::CI_BIT]) begin
			cnt_r <= 32'h0;
		end else if (cnt_r < PULSE_CYC) begin
			cnt_r <= cnt_r + 32'h1;
		end
	end
	sequence s_cfg_wr;
		reg_wr && reg_addr == fti_pkg::A_CFG;
	endsequence
	sequence s_cfg_rd;
		reg_rd && reg_addr == fti_pkg::A_CFG;
	endsequence
	property p_cfg_rb;
		s_cfg_wr ##2 s_cfg_rd |=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_cfg_rb: assert property (p_cfg_rb) else $error("cfg readback");
	property p_vid;
		reg_rd && reg_addr == fti_pkg::A_FANDIV
			|=> reg_rdata[3:0] == $past(vid_in);
	endproperty
	a_vid: assert property (p_vid) else $error("vid bits wrong");
	property p_unmap;
		reg_rd && reg_addr > fti_pkg::A_CICLR |=> reg_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped not zero");
	property p_pulse;
		intrusion_pin_oe == (cnt_r < PULSE_CYC);
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse length");
	property p_odrain;
		!intrusion_pin_o;
	endproperty
	a_odrain: assert property (p_odrain) else $error("pin driven high");
	property p_gate;
		!cfg_r[fti_pkg::CFG_INTEN] || cfg_r[fti_pkg::CFG_INTCLR] |=> int_n;
	endproperty
	a_gate: assert property (p_gate) else $error("int_n not gated");
	property p_mask;
		&mask_r[2:0] |=> int_n;
	endproperty
	a_mask: assert property (p_mask) else $error("mask ignored");
	property p_ci_stat;
		intrusion_pin_i && !intrusion_pin_oe ##1
			reg_rd && reg_addr == fti_pkg::A_STAT
			|=> reg_rdata[fti_pkg::ST_INTR];
	endproperty
	a_ci_stat: assert property (p_ci_stat) else $error("no status");
	property p_ci_int;
		intrusion_pin_i && !intrusion_pin_oe && !reg_wr && cfg_r[1]
			&& !cfg_r[3] && !mask_r[2] |-> ##2 !int_n;
	endproperty
	a_ci_int: assert property (p_ci_int) else $error("int_n high");
endmodule
bind fti_top fti_top_asserts #(.REF_DIV(REF_DIV), .PULSE_CYC(PULSE_CYC))
	chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .tach_input_a(tach_input_a),
	.tach_input_b(tach_input_b), .vid_in(vid_in),
	.intrusion_pin_i(intrusion_pin_i), .intrusion_pin_o(intrusion_pin_o),
	.intrusion_pin_oe(intrusion_pin_oe), .int_n(int_n));

/* tb/fti_far_side.sv */
// far side model: two fan tach outputs and the intrusion latch
`timescale 1ns/1ps
module fti_far_side (
	input  wire logic        sys_clk,
	input  wire logic        run_a,
	input  wire logic        run_b,
	input  wire logic [15:0] half_a,
	input  wire logic [15:0] half_b,
	input  wire logic        intrude,
	input  wire logic        pin_oe,
	output logic             tach_a = 1'b0,
	output logic             tach_b = 1'b0,
	output logic             pin_i
);
	logic [15:0] cnt_a   = 16'h0001;
	logic [15:0] cnt_b   = 16'h0001;
	logic        latch_r = 1'b0;
	// square waves; a stopped fan stands still low, as a dead rotor would
	always @(posedge sys_clk) begin
		cnt_a  <= (cnt_a >= half_a) ? 16'h0001 : cnt_a + 16'h0001;
		tach_a <= run_a & (tach_a ^ (cnt_a >= half_a));
		cnt_b  <= (cnt_b >= half_b) ? 16'h0001 : cnt_b + 16'h0001;
		tach_b <= run_b & (tach_b ^ (cnt_b >= half_b));
	end
	// battery-backed latch: set by an intrusion, held until pulled low
	always @(posedge sys_clk) begin
		if (pin_oe) begin
			latch_r <= 1'b0;
		end else if (intrude) begin
			latch_r <= 1'b1;
		end
	end
	// open drain: the monitor's low pulse overrides the latch output
	assign pin_i = pin_oe ? 1'b0 : latch_r;
endmodule

/* tb/fti_top_tb.sv */
// self-checking bench for the fan tach and intrusion monitor
`timescale 1ns/1ps
module fti_top_tb;
	localparam int unsigned PULSE = 20;
	logic        sys_clk   = 1'b0;
	logic        sys_rst   = 1'b1;
	logic [7:0]  reg_addr  = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        run_a     = 1'b1;
	logic        run_b     = 1'b1;
	logic        intrude   = 1'b0;
	logic [15:0] half_a    = 16'h0064;
	logic [15:0] half_b    = 16'h00C8;
	logic [3:0]  vid       = 4'hA;
	logic [7:0]  reg_rdata;
	logic [7:0]  rdat;
	logic        tach_a, tach_b, pin_i, pin_o, pin_oe, int_n;
	int          failures    = 0;
	int          checks_done = 0;
	// 200 MHz system clock
	always #2.5 sys_clk = ~sys_clk;
	fti_top #(.REF_DIV(4), .PULSE_CYC(PULSE)) dut_u (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tach_input_a(tach_a), .tach_input_b(tach_b),
		.vid_in(vid), .intrusion_pin_i(pin_i), .intrusion_pin_o(pin_o),
		.intrusion_pin_oe(pin_oe), .int_n(int_n));
	fti_far_side far_u (.sys_clk(sys_clk), .run_a(run_a), .run_b(run_b),
		.half_a(half_a), .half_b(half_b), .intrude(intrude),
		.pin_oe(pin_oe), .tach_a(tach_a), .tach_b(tach_b), .pin_i(pin_i));
	// wait n edges, then step past them so outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// a count of the prescaled reference may land one tick either side
	task automatic chk(input logic [7:0] got, input int e, input int tol);
		checks_done++;
		if ((got + tol >= e && got <= e + tol) !== 1'b1) begin
			failures++;
			$display("mismatch at %0t: got %h, want %0d", $time, got, e);
		end
	endtask
	// one strobe cycle; read data is taken in the cycle after the strobe
	task automatic bus(input logic w, input logic [7:0] a, d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= w;
		reg_rd    <= !w;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 rdat = reg_rdata;
	endtask
	task automatic rc(input logic [7:0] a, input int e, input int tol);
		bus(1'b0, a, 8'h00);
		chk(rdat, e, tol);
	endtask
	task automatic test_done;
		if (failures == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// cut a hang short well after the longest expected run
	initial begin
		#400000;
		failures++;
		test_done;
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rc(fti_pkg::A_CFG, 8'h00, 0);
		rc(fti_pkg::A_CHMODE, 8'h00, 0);
		rc(fti_pkg::A_FANDIV, 8'h5A, 0);
		vid <= 4'h3;
		rc(fti_pkg::A_FANDIV, 8'h53, 0);
		rc(fti_pkg::A_LIM_B, 8'hFF, 0);
		rc(fti_pkg::A_STAT, 8'h00, 0);
		bus(1'b1, 8'h20, 8'h55);
		rc(8'h20, 8'h00, 0);
		bus(1'b1, fti_pkg::A_CFG, 8'h01);
		// fan A period 200 clocks, fan B 400; every prescaler code on A
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, fti_pkg::A_FANDIV, {2'b01, c[1:0], 4'h0});
			cyc(3600);
			rc(fti_pkg::A_VAL_A, 100 >> c, 1);
			rc(fti_pkg::A_VAL_B, 100, 1);
		end
		// low-speed limit on fan A, masked then unmasked, then cleared
		bus(1'b1, fti_pkg::A_FANDIV, 8'h50);
		bus(1'b1, fti_pkg::A_LIM_A, 8'h28);
		bus(1'b1, fti_pkg::A_MASK, 8'h01);
		bus(1'b1, fti_pkg::A_CFG, 8'h03);
		rc(fti_pkg::A_CFG, 8'h03, 0);
		cyc(3600);
		chk({7'h00, int_n}, 1, 0);
		rc(fti_pkg::A_STAT, 8'h01, 0);
		bus(1'b1, fti_pkg::A_MASK, 8'h00);
		cyc(3600);
		chk({7'h00, int_n}, 0, 0);
		bus(1'b1, fti_pkg::A_CFG, 8'h0B);
		cyc(2);
		chk({7'h00, int_n}, 1, 0);
		rc(fti_pkg::A_STAT, 8'h01, 0);
		rc(fti_pkg::A_STAT, 8'h00, 0);
		rc(fti_pkg::A_VAL_A, 50, 1);
		// fan B stalls: its count must stop at full scale
		bus(1'b1, fti_pkg::A_CFG, 8'h01);
		bus(1'b1, fti_pkg::A_FANDIV, 8'h10);
		bus(1'b1, fti_pkg::A_LIM_B, 8'hFE);
		run_b <= 1'b0;
		cyc(4000);
		rc(fti_pkg::A_VAL_B, 8'hFF, 0);
		rc(fti_pkg::A_STAT, 8'h03, 0);
		// fan A pin given to the analog side: its value must freeze
		bus(1'b1, fti_pkg::A_CHMODE, 8'h01);
		rc(fti_pkg::A_CHMODE, 8'h01, 0);
		cyc(1000);
		half_a <= 16'h00C8;
		cyc(3000);
		rc(fti_pkg::A_VAL_A, 50, 1);
		bus(1'b1, fti_pkg::A_CHMODE, 8'h00);
		cyc(3600);
		rc(fti_pkg::A_VAL_A, 100, 1);
		// both pins analog: the loop parks, fan A keeps its last value
		bus(1'b1, fti_pkg::A_CHMODE, 8'h03);
		cyc(1500);
		half_a <= 16'h0064;
		cyc(2000);
		rc(fti_pkg::A_VAL_A, 100, 1);
		bus(1'b1, fti_pkg::A_CHMODE, 8'h00);
		// intrusion: status, interrupt, then the latch reset pulse
		bus(1'b1, fti_pkg::A_MASK, 8'h03);
		bus(1'b1, fti_pkg::A_CFG, 8'h03);
		cyc(2);
		chk({7'h00, int_n}, 1, 0);
		intrude <= 1'b1;
		cyc(1);
		intrude <= 1'b0;
		cyc(4);
		chk({7'h00, int_n}, 0, 0);
		rc(fti_pkg::A_STAT, 8'h07, 0);
		cyc(4);
		chk({7'h00, int_n}, 0, 0);
		bus(1'b1, fti_pkg::A_CICLR, 8'h80);
		chk({7'h00, pin_oe}, 1, 0);
		rc(fti_pkg::A_CICLR, 8'h80, 0);
		cyc(PULSE);
		chk({7'h00, pin_oe}, 0, 0);
		bus(1'b0, fti_pkg::A_STAT, 8'h00);
		chk(rdat & 8'h04, 4, 0);
		bus(1'b0, fti_pkg::A_STAT, 8'h00);
		chk(rdat & 8'h04, 0, 0);
		cyc(2);
		chk({7'h00, int_n}, 1, 0);
		rc(fti_pkg::A_CICLR, 8'h00, 0);
		bus(1'b1, fti_pkg::A_MASK, 8'h07);
		cyc(2);
		chk({7'h00, int_n}, 1, 0);
		test_done;
	end
endmodule
